//--- arf_pkg.sv
// package: register map, field layout and constants of the converter result formatter
package arf_pkg;
   // register byte addresses on the apb bus
   localparam logic [7:0] ARF_OFF_RESULT_LOW = 8'h00;
   localparam logic [7:0] ARF_OFF_RESULT_HIGH = 8'h04;
   localparam logic [7:0] ARF_OFF_CHANNEL_SEL = 8'h08;
   localparam logic [7:0] ARF_OFF_CONTROL_A = 8'h0C;
   localparam logic [7:0] ARF_OFF_CAL = 8'h10;
   // channel select register fields
   localparam int ARF_CH_LEFT_POS = 5;
   localparam int ARF_CH_REF_POS = 6;
   localparam logic [7:0] ARF_CH_RESET = 8'h00;
   localparam logic [4:0] ARF_CH_TEMP_SENSOR = 5'h10;
   localparam logic [1:0] ARF_REF_INT_2V56 = 2'h3;
   // control register a fields
   localparam int ARF_CTL_START_POS = 6;
   localparam int ARF_CTL_FLAG_POS = 4;
   localparam logic [7:0] ARF_CTL_RESET = 8'h00;
   // result codes
   localparam logic [9:0] ARF_SE_MIN = 10'h000;
   localparam logic [9:0] ARF_SE_MAX = 10'h3FF;
   localparam logic [9:0] ARF_DIFF_MIN = 10'h200;
   localparam logic [9:0] ARF_DIFF_MAX = 10'h1FF;
   localparam logic [9:0] ARF_RESULT_RESET = 10'h000;
   // calibration defaults: gain 0x80 means 1.0, offset is signed
   localparam logic [7:0] ARF_GAIN_ONE = 8'h80;
   localparam logic [7:0] ARF_OFFSET_ZERO = 8'h00;

   typedef struct packed
   {
      logic [1:0] ref_sel;
      logic [4:0] channel;
      logic differential;
   } arf_setting_s;

   typedef struct packed
   {
      logic valid;
      logic [9:0] code;
   } arf_sample_s;
endpackage

//--- arf_coder.sv
// coder: turns a raw analog sample into a 10-bit result code
`timescale 1ns/1ns
module arf_coder
(
   input wire logic [10:0] sample_i,
   input wire logic differential_i,
   output logic [9:0] code_o
);
   import arf_pkg::*;
   // single-ended samples are 0..1023; differential samples are signed -512..511 (top bit = sign)
   always_comb
   begin
      if (differential_i)
      begin
         if ($signed(sample_i) > $signed({1'b0, ARF_DIFF_MAX}))
            code_o = ARF_DIFF_MAX;
         else if ($signed(sample_i) < $signed({1'b1, ARF_DIFF_MIN}))
            code_o = ARF_DIFF_MIN;
         else
            code_o = sample_i[9:0];
      end
      else
      begin
         if (sample_i[10])
            code_o = ARF_SE_MAX;
         else
            code_o = sample_i[9:0];
      end
   end
endmodule

//--- arf_align.sv
// aligner: places the 10-bit result left or right justified over two bytes
`timescale 1ns/1ns
module arf_align
(
   input wire logic [9:0] code_i,
   input wire logic left_i,
   output logic [7:0] low_o,
   output logic [7:0] high_o
);
   // purely combinational so a change of alignment shows at once
   always_comb
   begin
      if (left_i)
      begin
         high_o = code_i[9:2];
         low_o = {code_i[1:0], 6'h00};
      end
      else
      begin
         high_o = {6'h00, code_i[9:8]};
         low_o = code_i[7:0];
      end
   end
endmodule

//--- arf_top.sv
// top: apb register file, conversion sequencing and result formatting
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ns
module arf_top
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic conv_done_i,
   input wire logic [10:0] conv_sample_i,
   input wire logic conv_differential_i,
   input wire logic [7:0] sensor_gain_cal_i,
   input wire logic [7:0] sensor_offset_cal_i,
   output logic conv_start_o,
   output logic [4:0] active_channel_o,
   output logic [1:0] active_reference_o,
   output logic sensor_enable_o
);
   import arf_pkg::*;

   // ===========================================================
   // bus decode
   logic apb_setup;
   logic apb_write;
   logic [7:0] channel_select_register_q;
   logic [7:0] converter_control_register_a_q;
   logic busy_q;
   logic conversion_complete_flag_q;
   arf_setting_s active_q;
   arf_sample_s result_q;
   logic [9:0] code;
   logic [7:0] result_low_byte;
   logic [7:0] result_high_byte;
   logic [7:0] sensor_gain_cal_q;
   logic [7:0] sensor_offset_cal_q;
   logic [31:0] read_word;
   logic addr_ok;

   // zero-wait slave: answer in the access cycle itself
   assign apb_setup = psel_i & ~penable_i;
   assign apb_write = psel_i & penable_i & pwrite_i & pready_o;

   // ===========================================================
   // software registers
   // channel select register: reference, alignment and channel fields
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         channel_select_register_q <= ARF_CH_RESET;
      else if (apb_write && paddr_i == ARF_OFF_CHANNEL_SEL)
         channel_select_register_q <= pwdata_i[7:0];
   end

   // control register a: start bit written by software, cleared by hardware on launch
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         converter_control_register_a_q <= ARF_CTL_RESET;
      else if (apb_write && paddr_i == ARF_OFF_CONTROL_A)
         converter_control_register_a_q <= pwdata_i[7:0] & ~(8'h01 << ARF_CTL_FLAG_POS);
      else if (converter_control_register_a_q[ARF_CTL_START_POS] && !busy_q)
         converter_control_register_a_q[ARF_CTL_START_POS] <= 1'b0;
   end

   // ===========================================================
   // conversion sequencing
   // channel and reference are latched at launch so mid-conversion writes to them wait for completion
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         busy_q <= 1'b0;
         conv_start_o <= 1'b0;
         active_q <= '0;
      end
      else
      begin
         conv_start_o <= 1'b0;
         if (!busy_q)
         begin
            // idle: channel and reference follow software directly, differential follows conv_differential_i
            active_q.ref_sel <= channel_select_register_q[ARF_CH_REF_POS +: 2];
            active_q.channel <= channel_select_register_q[4:0];
            active_q.differential <= conv_differential_i;
            if (converter_control_register_a_q[ARF_CTL_START_POS])
            begin
               busy_q <= 1'b1;
               conv_start_o <= 1'b1;
            end
         end
         else if (conv_done_i)
            busy_q <= 1'b0;
      end
   end

   // completion flag: set by hardware, cleared by writing one; set wins over clear
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         conversion_complete_flag_q <= 1'b0;
      else if (busy_q && conv_done_i)
         conversion_complete_flag_q <= 1'b1;
      else if (apb_write && paddr_i == ARF_OFF_CONTROL_A && pwdata_i[ARF_CTL_FLAG_POS])
         conversion_complete_flag_q <= 1'b0;
   end

   // ===========================================================
   // result capture and formatting
   arf_coder u_coder
   (
      .sample_i(conv_sample_i),
      .differential_i(active_q.differential),
      .code_o(code)
   );

   // result stored with the flag in the same edge, then held
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         result_q <= '{valid: 1'b0, code: ARF_RESULT_RESET};
      else if (busy_q && conv_done_i)
         result_q <= '{valid: 1'b1, code: code};
   end

   // alignment applied at read time so the bit acts immediately
   arf_align u_align
   (
      .code_i(result_q.code),
      .left_i(channel_select_register_q[ARF_CH_LEFT_POS]),
      .low_o(result_low_byte),
      .high_o(result_high_byte)
   );

   // ===========================================================
   // channel outputs and calibration bytes
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         active_channel_o <= 5'h00;
         active_reference_o <= 2'h0;
         sensor_enable_o <= 1'b0;
      end
      else
      begin
         active_channel_o <= active_q.channel;
         active_reference_o <= active_q.ref_sel;
         sensor_enable_o <= (active_q.channel == ARF_CH_TEMP_SENSOR);
      end
   end

   // factory calibration: gain unsigned with 0x80 as 1.0, offset signed
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         sensor_gain_cal_q <= ARF_GAIN_ONE;
         sensor_offset_cal_q <= ARF_OFFSET_ZERO;
      end
      else
      begin
         sensor_gain_cal_q <= sensor_gain_cal_i;
         sensor_offset_cal_q <= sensor_offset_cal_i;
      end
   end

   // ===========================================================
   // read mux
   always_comb
   begin
      read_word = 32'h0000_0000;
      addr_ok = 1'b1;
      case (paddr_i)
         ARF_OFF_RESULT_LOW: read_word = {24'h000000, result_low_byte};
         ARF_OFF_RESULT_HIGH: read_word = {24'h000000, result_high_byte};
         ARF_OFF_CHANNEL_SEL: read_word = {24'h000000, channel_select_register_q};
         ARF_OFF_CONTROL_A:
            read_word = {24'h000000, converter_control_register_a_q}
                        | ({31'h0, conversion_complete_flag_q} << ARF_CTL_FLAG_POS);
         ARF_OFF_CAL: read_word = {16'h0000, sensor_offset_cal_q, sensor_gain_cal_q};
         default: addr_ok = 1'b0;
      endcase
   end

   // answer registered in setup so every bus output comes from a flip-flop
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         prdata_o <= 32'h0000_0000;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end
      else
      begin
         pready_o <= apb_setup;
         pslverr_o <= apb_setup & ~addr_ok;
         prdata_o <= (apb_setup && !pwrite_i) ? read_word : 32'h0000_0000;
      end
   end
endmodule

//--- arf_asserts.sv
// checker: apb and result-format assertions bound to the formatter top
`timescale 1ns/1ns
module arf_asserts
   import arf_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic conv_done_i,
   input wire logic [10:0] conv_sample_i,
   input wire logic conv_differential_i,
   input wire logic [7:0] sensor_gain_cal_i,
   input wire logic [7:0] sensor_offset_cal_i,
   input wire logic conv_start_o,
   input wire logic [4:0] active_channel_o,
   input wire logic [1:0] active_reference_o,
   input wire logic sensor_enable_o
);
   // ==========================================
   // helper state
   logic busy_q, flag_q, left_q, rd, wr;
   // finished accesses, seen at the pready edge
   assign rd = psel_i && penable_i && pready_o && !pwrite_i;
   assign wr = psel_i && penable_i && pready_o && pwrite_i;
   // busy from launch to completion; a done while idle is ignored
   always_ff @(posedge clk_i or negedge reset_n_i)
      if (!reset_n_i)
         busy_q <= 1'b0;
      else if (conv_start_o)
         busy_q <= 1'b1;
      else if (conv_done_i)
         busy_q <= 1'b0;
   // flag model: completion wins over a write-one clear
   always_ff @(posedge clk_i or negedge reset_n_i)
      if (!reset_n_i)
         flag_q <= 1'b0;
      else if (busy_q && conv_done_i)
         flag_q <= 1'b1;
      else if (wr && paddr_i == ARF_OFF_CONTROL_A && pwdata_i[ARF_CTL_FLAG_POS])
         flag_q <= 1'b0;
   // alignment bit as last written
   always_ff @(posedge clk_i or negedge reset_n_i)
      if (!reset_n_i)
         left_q <= 1'b0;
      else if (wr && paddr_i == ARF_OFF_CHANNEL_SEL)
         left_q <= pwdata_i[ARF_CH_LEFT_POS];
   // ==========================================
   // assertions
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   ready_after_setup_a: assert property (psel_i && !penable_i |=> pready_o)
      else $error("no pready after setup");
   error_with_ready_a: assert property (pslverr_o |-> pready_o)
      else $error("pslverr without pready");
   sensor_follow_a: assert property (sensor_enable_o == (active_channel_o == ARF_CH_TEMP_SENSOR))
      else $error("sensor enable wrong");
   sel_hold_a: assert property (busy_q && !conv_done_i |=> $stable({active_channel_o, active_reference_o}))
      else $error("selection moved mid conversion");
   flag_read_a: assert property (rd && paddr_i == ARF_OFF_CONTROL_A |-> prdata_o[4] == $past(flag_q))
      else $error("completion flag wrong");
   right_align_a: assert property (rd && paddr_i == ARF_OFF_RESULT_HIGH && !left_q |-> prdata_o[7:2] == 6'h00)
      else $error("right aligned high byte wrong");
   left_align_a: assert property (rd && paddr_i == ARF_OFF_RESULT_LOW && left_q |-> prdata_o[5:0] == 6'h00)
      else $error("left aligned low byte wrong");
   // read data is launched at setup from the captured bytes, two edges behind the pins
   cal_read_a: assert property (rd && paddr_i == ARF_OFF_CAL |-> prdata_o[15:0] == {$past(sensor_offset_cal_i, 2), $past(sensor_gain_cal_i, 2)})
      else $error("calibration bytes wrong");
endmodule
bind arf_top arf_asserts u_arf_asserts (.*);

//--- arf_bench.sv
// bench: register-level tests of the result formatter over apb
`timescale 1ns/1ns
module arf_bench;
   import arf_pkg::*;
   logic clk_i = 1'b0, reset_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic conv_done_i = 1'b0, conv_differential_i = 1'b0, pready_o, pslverr_o, conv_start_o, sensor_enable_o, e;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h00000000, prdata_o, r, res;
   logic [10:0] conv_sample_i = 11'h000;
   logic [4:0] active_channel_o;
   logic [1:0] active_reference_o;
   logic [10:0] s_in [7] = '{11'h000, 11'h3FF, 11'h7FF, 11'h12C, 11'h670, 11'h5A8, 11'h258};
   logic [9:0] c_out [7] = '{10'h000, 10'h3FF, 10'h3FF, 10'h12C, 10'h270, 10'h200, 10'h1FF};
   int n_mismatch = 0, checks = 0, i;
   // ==========================================
   // clock and device; calibration bytes are fixed by the factory
   always #25 clk_i = ~clk_i;
   arf_top dut (.*, .sensor_gain_cal_i(8'h80), .sensor_offset_cal_i(8'hF6));
   // ==========================================
   // tasks
   task stop_test;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // bounded wait for pready or a launch pulse, sampled at the edge
   task wt(input logic s);
      for (int k = 0; k < 20 && (s ? conv_start_o : pready_o) !== 1'b1; k++)
         @(posedge clk_i);
      if ((s ? conv_start_o : pready_o) !== 1'b1)
      begin
         n_mismatch++;
         stop_test;
      end
   endtask
   // request held until pready is seen high, then released
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      wt(1'b0);
      r = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   // start plus flag clear in one write
   task go(input logic d);
      conv_differential_i <= d;
      apb(1'b1, ARF_OFF_CONTROL_A, 32'h00000050);
      wt(1'b1);
   endtask
   task done(input logic [10:0] s);
      @(posedge clk_i);
      conv_done_i <= 1'b1;
      conv_sample_i <= s;
      @(posedge clk_i);
      conv_done_i <= 1'b0;
      apb(1'b0, ARF_OFF_CONTROL_A, 32'h00000000);
      chk(r[4], 32'h00000001);
   endtask
   task rdres;
      apb(1'b0, ARF_OFF_RESULT_LOW, 32'h00000000);
      res[7:0] = r[7:0];
      apb(1'b0, ARF_OFF_RESULT_HIGH, 32'h00000000);
      res = {16'h0000, r[7:0], res[7:0]};
   endtask
   // expected byte pair, high byte first
   function logic [15:0] fmt(input logic [9:0] c, input logic l);
      return l ? {c, 6'h00} : {6'h00, c};
   endfunction
   // ==========================================
   // main sequence
   initial
   begin
      repeat (16) @(posedge clk_i);
      reset_n_i <= 1'b1;
      apb(1'b0, ARF_OFF_CAL, 32'h00000000);
      chk(r, 32'h0000F680);
      apb(1'b0, 8'h14, 32'h00000000);
      chk({r[31:1], e}, 32'h00000001);
      // sensor channel on the internal 2.56V reference, one single conversion at a time
      apb(1'b1, ARF_OFF_CHANNEL_SEL, 32'h000000D0);
      for (i = 0; i < 7; i++)
      begin
         go(i > 3);
         // mid conversion: alignment acts at once, channel waits
         if (i == 4)
         begin
            apb(1'b1, ARF_OFF_CHANNEL_SEL, 32'h000000E1);
            rdres;
            chk(res, {16'h0000, fmt(10'h12C, 1'b1)});
            chk(active_channel_o, 32'h00000010);
            apb(1'b0, ARF_OFF_CONTROL_A, 32'h00000000);
            chk(r[4], 32'h00000000);
         end
         done(s_in[i]);
         rdres;
         chk(res, {16'h0000, fmt(c_out[i], i > 3)});
         if (i == 0)
            chk({active_reference_o, active_channel_o, sensor_enable_o}, 32'h000000E1);
         if (i == 4)
            chk({active_channel_o, sensor_enable_o}, 32'h00000002);
      end
      // a stray completion while idle leaves the result alone
      done(11'h000);
      rdres;
      chk(res, 32'h00007FC0);
      apb(1'b1, ARF_OFF_CHANNEL_SEL, 32'h00000001);
      rdres;
      chk(res, 32'h000001FF);
      stop_test;
   end
endmodule
